// ===== hdl/codec_ctrl_decode.sv
// control register decoder of the codec: address select, class decode,
// status, direct and extended sound registers, peak read-out
// assumes peak level comes from the playback datapath on CLK_I
//
// Notes on behaviour
// - address byte low bits choose transfer class
// - top bits pick register, rest is value
// - direct sound write selects by top two bits
// - extended pointer first, then five-bit value
// - peak read class returns peak level to host
// - status bank zero: defaults, ratio, format, offset
// - status bank one: boosts, inverts, rate, power
// - defaults load keeps clock ratio; zero writes ratio, format, offset
// - ratio 00/01/10 give 512/384/256 fs
// - offset bit enables record DC filter
// - format field selects serial data format
// - DAC boost bit gives 0 or 6 dB
// - ADC boost bit gives 0 or 6 dB
// - ADC invert bit flips recorded polarity
// - DAC invert bit flips playback polarity
// - double rate bit selects double speed playback
// - power field switches converters off individually
// - power 00 off, 01 DAC, 10 ADC, 11 both
// - status defaults: 0 dB, non-inverting, single, on
// - direct defaults: 0 dB, tap after tone, flat
// - extended defaults per fixed default table
// - class codes 00 sound, 01 peak, 10 status
// - commit byte only after all eight bits
// - direct selectors 00,01,10,110 pointer,111 value
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_decode (
	input wire logic CLK_I,                       // system clock
	input wire logic SYS_RST_I,                   // async reset, high
	input wire logic CTRL_DATA_I,                 // data pin in
	output logic CTRL_DATA_O,                     // data pin out
	output logic CTRL_DATA_OE_N_O,                // data enable, low
	input wire logic CTRL_MODE_I,                 // mode pin
	input wire logic CTRL_CLK_I,                  // link clock pin
	input wire logic [codec_ctrl_pkg::PEAK_W-1:0] PEAK_LEVEL_I, // held peak
	output logic PEAK_CLEAR_O,                    // peak read done
	output logic [1:0] MASTER_CLOCK_RATIO_O,      // ratio code
	output logic [9:0] CLOCK_MULT_O,              // fs multiple
	output logic [2:0] SERIAL_FORMAT_O,           // format code
	output logic FMT_I2S_O,                       // i2s format
	output logic FMT_MSB_OUT_O,                   // msb-justified out
	output logic FMT_LSB_IN_O,                    // lsb-justified in
	output logic [1:0] FMT_LSB_WIDTH_O,           // 1/2/3 = 16/18/20
	output logic OFFSET_REMOVAL_ENABLE_O,         // record DC filter
	output logic DAC_OUTPUT_BOOST_O,              // DAC +6 dB
	output logic ADC_INPUT_BOOST_O,               // ADC +6 dB
	output logic ADC_INVERT_O,                    // record invert
	output logic DAC_INVERT_O,                    // playback invert
	output logic DOUBLE_RATE_O,                   // double speed
	output logic [1:0] CONVERTER_POWER_FIELD_O,   // power code
	output logic ADC_POWER_ON_O,                  // ADC powered
	output logic DAC_POWER_ON_O,                  // DAC powered
	output logic [5:0] VOLUME_ATTEN_O,            // volume code
	output logic [3:0] LOW_SHELF_GAIN_O,          // bass code
	output logic [1:0] HIGH_SHELF_GAIN_O,         // treble code
	output logic PEAK_TAP_POINT_O,                // 1 = after tone
	output logic [1:0] EMPHASIS_UNDO_SELECT_O,    // de-emphasis code
	output logic MUTE_ENABLE_O,                   // digital mute
	output logic [1:0] TONE_MODE_O,               // tone filter mode
	output logic [4:0] MIXER_GAIN_CH1_O,          // mixer ch1 code
	output logic [4:0] MIXER_GAIN_CH2_O,          // mixer ch2 code
	output logic [2:0] MIC_SENSITIVITY_O,         // mic code
	output logic [1:0] MIXER_MODE_O,              // mixer mode
	output logic AUTO_GAIN_ENABLE_O,              // agc on
	output logic [6:0] INPUT_GAIN_O,              // input gain code
	output logic [2:0] AUTO_GAIN_TIME_O,          // agc time code
	output logic [1:0] AUTO_GAIN_LEVEL_O          // agc level code
);
	import codec_ctrl_pkg::*;

	typedef struct packed {
		logic [1:0] ratio;
		logic [2:0] fmt;
		logic dc;
		logic dac_boost;
		logic adc_boost;
		logic adc_inv;
		logic dac_inv;
		logic dbl;
		logic [1:0] power;
		logic [5:0] vol;
		logic [3:0] low_shelf;
		logic [1:0] high_shelf;
		logic tap;
		logic [1:0] emph;
		logic mute;
		logic [1:0] tone;
		logic [4:0] mix1;
		logic [4:0] mix2;
		logic [2:0] mic;
		logic [1:0] mix_mode;
		logic agc;
		logic [6:0] in_gain;
		logic [2:0] agc_time;
		logic [1:0] agc_level;
	} cfg_t;

	typedef struct packed {
		logic sel;
		logic [1:0] xtype;
		logic [2:0] ext_ptr;
		logic tx_en;
		logic peak_clr;
		cfg_t cfg;
		logic [9:0] mult;
		logic i2s;
		logic msb_out;
		logic lsb_in;
		logic [1:0] lsb_w;
	} top_state_t;

	localparam cfg_t CFG_DEFAULT = '{
		ratio: DEF_RATIO, fmt: DEF_FMT, dc: DEF_DC,
		dac_boost: DEF_BOOST, adc_boost: DEF_BOOST,
		adc_inv: DEF_INVERT, dac_inv: DEF_INVERT,
		dbl: DEF_DOUBLE, power: DEF_POWER,
		vol: DEF_VOLUME, low_shelf: DEF_LOW_SHELF,
		high_shelf: DEF_HIGH_SHELF, tap: DEF_PEAK_TAP,
		emph: DEF_EMPH, mute: DEF_MUTE, tone: DEF_TONE,
		mix1: DEF_MIX_GAIN, mix2: DEF_MIX_GAIN, mic: DEF_MIC,
		mix_mode: DEF_MIX_MODE, agc: DEF_AGC, in_gain: DEF_IN_GAIN,
		agc_time: DEF_AGC_TIME, agc_level: DEF_AGC_LEVEL
	};

	link_byte_if lnk ();
	top_state_t q_ff, nxt_q;
	logic [7:0] b;

	link_shifter u_shift (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.data_i(CTRL_DATA_I),
		.mode_i(CTRL_MODE_I),
		.sclk_i(CTRL_CLK_I),
		.lnk(lnk.rx),
		.data_o(CTRL_DATA_O),
		.data_oe_n_o(CTRL_DATA_OE_N_O)
	);

	// peak level sits in the low bits, upper bits read as zero
	assign lnk.tx_byte = {{(8-PEAK_W){1'b0}}, PEAK_LEVEL_I};
	assign lnk.tx_en = q_ff.tx_en;

	always_comb begin
		nxt_q = q_ff;
		nxt_q.peak_clr = 1'b0;
		b = lnk.byte_data;
		if (lnk.byte_valid) begin
			if (lnk.byte_is_addr) begin
				// a foreign address deselects until the next address byte
				nxt_q.sel = (b[ADDR_HI:ADDR_LO] == DEV_ADDR);
				nxt_q.xtype = b[1:0];
			end else if (q_ff.sel) begin
				case (q_ff.xtype)
				STATUS_TYPE: begin
					if (!b[ST_BANK_BIT]) begin
						if (b[ST_DEFAULTS_BIT]) begin
							nxt_q.cfg = CFG_DEFAULT;
							nxt_q.cfg.ratio = q_ff.cfg.ratio;
							nxt_q.ext_ptr = 3'h0;
						end else begin
							nxt_q.cfg.ratio = b[5:4];
							nxt_q.cfg.fmt = b[3:1];
							nxt_q.cfg.dc = b[0];
						end
					end else begin
						nxt_q.cfg.dac_boost = b[6];
						nxt_q.cfg.adc_boost = b[5];
						nxt_q.cfg.adc_inv = b[4];
						nxt_q.cfg.dac_inv = b[3];
						nxt_q.cfg.dbl = b[2];
						nxt_q.cfg.power = b[1:0];
					end
				end
				SOUND_WRITE_TYPE: begin
					case (b[7:6])
					SEL_VOLUME: nxt_q.cfg.vol = b[5:0];
					SEL_SHELF: begin
						nxt_q.cfg.low_shelf = b[5:2];
						nxt_q.cfg.high_shelf = b[1:0];
					end
					SEL_MISC: begin
						nxt_q.cfg.tap = b[5];
						nxt_q.cfg.emph = b[4:3];
						nxt_q.cfg.mute = b[2];
						nxt_q.cfg.tone = b[1:0];
					end
					SEL_EXT: begin
						if (!b[EXT_VALUE_BIT]) begin
							nxt_q.ext_ptr = b[2:0];
						end else begin
							// pointer is kept so a run of values can follow
							case (q_ff.ext_ptr)
							EXT_MIX1: nxt_q.cfg.mix1 = b[4:0];
							EXT_MIX2: nxt_q.cfg.mix2 = b[4:0];
							EXT_MIC: begin
								nxt_q.cfg.mic = b[4:2];
								nxt_q.cfg.mix_mode = b[1:0];
							end
							EXT_AGC_GAIN_LO: begin
								nxt_q.cfg.agc = b[4];
								nxt_q.cfg.in_gain[1:0] = b[1:0];
							end
							EXT_GAIN_HI: nxt_q.cfg.in_gain[6:2] = b[4:0];
							EXT_AGC_TIME: begin
								nxt_q.cfg.agc_time = b[4:2];
								nxt_q.cfg.agc_level = b[1:0];
							end
							default: ;
							endcase
						end
					end
					default: ;
					endcase
				end
				PEAK_READ_TYPE: nxt_q.peak_clr = 1'b1;
				default: ;
				endcase
			end
		end
		nxt_q.tx_en = nxt_q.sel & (nxt_q.xtype == PEAK_READ_TYPE);
		case (nxt_q.cfg.ratio)
		RATIO_512: nxt_q.mult = MULT_512;
		RATIO_384: nxt_q.mult = MULT_384;
		RATIO_256: nxt_q.mult = MULT_256;
		default: nxt_q.mult = MULT_NONE;
		endcase
		nxt_q.i2s = (nxt_q.cfg.fmt == FMT_I2S);
		nxt_q.msb_out = nxt_q.cfg.fmt[2];
		nxt_q.lsb_in = (nxt_q.cfg.fmt[1:0] != 2'h0);
		nxt_q.lsb_w = nxt_q.cfg.fmt[1:0];
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			q_ff <= '0;
			q_ff.cfg <= CFG_DEFAULT;
			q_ff.mult <= MULT_512;
			q_ff.i2s <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign PEAK_CLEAR_O = q_ff.peak_clr;
	assign MASTER_CLOCK_RATIO_O = q_ff.cfg.ratio;
	assign CLOCK_MULT_O = q_ff.mult;
	assign SERIAL_FORMAT_O = q_ff.cfg.fmt;
	assign FMT_I2S_O = q_ff.i2s;
	assign FMT_MSB_OUT_O = q_ff.msb_out;
	assign FMT_LSB_IN_O = q_ff.lsb_in;
	assign FMT_LSB_WIDTH_O = q_ff.lsb_w;
	assign OFFSET_REMOVAL_ENABLE_O = q_ff.cfg.dc;
	assign DAC_OUTPUT_BOOST_O = q_ff.cfg.dac_boost;
	assign ADC_INPUT_BOOST_O = q_ff.cfg.adc_boost;
	assign ADC_INVERT_O = q_ff.cfg.adc_inv;
	assign DAC_INVERT_O = q_ff.cfg.dac_inv;
	assign DOUBLE_RATE_O = q_ff.cfg.dbl;
	assign CONVERTER_POWER_FIELD_O = q_ff.cfg.power;
	assign ADC_POWER_ON_O = q_ff.cfg.power[1];
	assign DAC_POWER_ON_O = q_ff.cfg.power[0];
	assign VOLUME_ATTEN_O = q_ff.cfg.vol;
	assign LOW_SHELF_GAIN_O = q_ff.cfg.low_shelf;
	assign HIGH_SHELF_GAIN_O = q_ff.cfg.high_shelf;
	assign PEAK_TAP_POINT_O = q_ff.cfg.tap;
	assign EMPHASIS_UNDO_SELECT_O = q_ff.cfg.emph;
	assign MUTE_ENABLE_O = q_ff.cfg.mute;
	assign TONE_MODE_O = q_ff.cfg.tone;
	assign MIXER_GAIN_CH1_O = q_ff.cfg.mix1;
	assign MIXER_GAIN_CH2_O = q_ff.cfg.mix2;
	assign MIC_SENSITIVITY_O = q_ff.cfg.mic;
	assign MIXER_MODE_O = q_ff.cfg.mix_mode;
	assign AUTO_GAIN_ENABLE_O = q_ff.cfg.agc;
	assign INPUT_GAIN_O = q_ff.cfg.in_gain;
	assign AUTO_GAIN_TIME_O = q_ff.cfg.agc_time;
	assign AUTO_GAIN_LEVEL_O = q_ff.cfg.agc_level;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	logic wr_dat, wr_sound, wr_status;
	assign wr_dat = lnk.byte_valid & ~lnk.byte_is_addr & q_ff.sel;
	assign wr_sound = wr_dat & (q_ff.xtype == SOUND_WRITE_TYPE);
	assign wr_status = wr_dat & (q_ff.xtype == STATUS_TYPE);

	a_addr_class: assert property (
		lnk.byte_valid && lnk.byte_is_addr && b[7:2] == DEV_ADDR
		|=> q_ff.sel && q_ff.xtype == $past(b[1:0]))
		else $error("class not latched from address byte");
	a_foreign_addr: assert property (
		lnk.byte_valid && lnk.byte_is_addr && b[7:2] != DEV_ADDR
		|=> !q_ff.sel ##1 !PEAK_CLEAR_O)
		else $error("foreign address did not deselect");
	a_volume_write: assert property (
		wr_sound && b[7:6] == SEL_VOLUME
		|=> VOLUME_ATTEN_O == $past(b[5:0]))
		else $error("volume byte not stored");
	a_ext_value: assert property (
		wr_sound && b[7:5] == 3'h7 && q_ff.ext_ptr == EXT_MIX2
		|=> MIXER_GAIN_CH2_O == $past(b[4:0])
		&& q_ff.ext_ptr == EXT_MIX2)
		else $error("extended value missed its pointer");
	a_defaults_load: assert property (
		wr_status && !b[7] && b[6]
		|=> CONVERTER_POWER_FIELD_O == DEF_POWER
		&& VOLUME_ATTEN_O == DEF_VOLUME && PEAK_TAP_POINT_O == DEF_PEAK_TAP
		&& $stable(MASTER_CLOCK_RATIO_O))
		else $error("defaults load wrong");
	a_gain_bank: assert property (
		wr_status && b[7]
		|=> {DAC_OUTPUT_BOOST_O, ADC_INPUT_BOOST_O, ADC_INVERT_O,
		DAC_INVERT_O, DOUBLE_RATE_O, CONVERTER_POWER_FIELD_O}
		== $past(b[6:0]))
		else $error("gain bank byte not stored");
	a_ratio_decode: assert property (
		wr_status && !b[7] && !b[6] && b[5:4] == RATIO_384
		|=> CLOCK_MULT_O == MULT_384 && MASTER_CLOCK_RATIO_O == RATIO_384)
		else $error("clock ratio decode wrong");
	a_hold_idle: assert property (
		!lnk.byte_valid |=> $stable(VOLUME_ATTEN_O)
		&& $stable(MIXER_GAIN_CH1_O) && $stable(CONVERTER_POWER_FIELD_O))
		else $error("register changed without a byte");
	a_peak_clear: assert property (
		wr_dat && q_ff.xtype == PEAK_READ_TYPE
		|=> PEAK_CLEAR_O ##1 !PEAK_CLEAR_O && $stable(VOLUME_ATTEN_O))
		else $error("peak read did not clear once");
	a_power_split: assert property (
		CONVERTER_POWER_FIELD_O == 2'h1 |-> DAC_POWER_ON_O && !ADC_POWER_ON_O)
		else $error("power decode wrong");

	c_peak_read: cover property (PEAK_CLEAR_O);
	c_defaults: cover property (wr_status && !b[7] && b[6]);
	c_ext_write: cover property (wr_sound && b[7:5] == 3'h7);
	c_drive_pin: cover property ($fell(CTRL_DATA_OE_N_O));
endmodule
`default_nettype wire

// ===== hdl/codec_ctrl_pkg.sv
// constants for the serial control-port register decoder of the codec
// assumes one system clock; link pins are asynchronous to it
package codec_ctrl_pkg;

	// device address in the upper six bits of an address byte
	localparam logic [5:0] DEV_ADDR = 6'h05;
	localparam int ADDR_HI = 7;
	localparam int ADDR_LO = 2;

	// transfer class in the two low bits of an address byte
	localparam logic [1:0] SOUND_WRITE_TYPE = 2'h0;
	localparam logic [1:0] PEAK_READ_TYPE = 2'h1;
	localparam logic [1:0] STATUS_TYPE = 2'h2;

	// status byte layout
	localparam int ST_BANK_BIT = 7;
	localparam int ST_DEFAULTS_BIT = 6;

	// direct sound-write selectors on bits 7:6, and bit 5 of selector 11
	localparam logic [1:0] SEL_VOLUME = 2'h0;
	localparam logic [1:0] SEL_SHELF = 2'h1;
	localparam logic [1:0] SEL_MISC = 2'h2;
	localparam logic [1:0] SEL_EXT = 2'h3;
	localparam int EXT_VALUE_BIT = 5;

	// extended pointer targets
	localparam logic [2:0] EXT_MIX1 = 3'h0;
	localparam logic [2:0] EXT_MIX2 = 3'h1;
	localparam logic [2:0] EXT_MIC = 3'h2;
	localparam logic [2:0] EXT_AGC_GAIN_LO = 3'h4;
	localparam logic [2:0] EXT_GAIN_HI = 3'h5;
	localparam logic [2:0] EXT_AGC_TIME = 3'h6;

	// master clock ratio codes and the multiplier each one selects
	localparam logic [1:0] RATIO_512 = 2'h0;
	localparam logic [1:0] RATIO_384 = 2'h1;
	localparam logic [1:0] RATIO_256 = 2'h2;
	localparam logic [9:0] MULT_512 = 10'h200;
	localparam logic [9:0] MULT_384 = 10'h180;
	localparam logic [9:0] MULT_256 = 10'h100;
	localparam logic [9:0] MULT_NONE = 10'h000;

	// serial format codes; bit 2 alone means msb out, whatever the low pair
	localparam logic [2:0] FMT_I2S = 3'h0;
	localparam logic [2:0] FMT_MSB = 3'h4;
	localparam logic [1:0] LSB_W16 = 2'h1;
	localparam logic [1:0] LSB_W18 = 2'h2;
	localparam logic [1:0] LSB_W20 = 2'h3;

	// peak level width returned in the low bits of a read byte
	localparam int PEAK_W = 6;

	// defaults loaded at reset and, except DEF_RATIO, by the defaults-load bit
	localparam logic [1:0] DEF_RATIO = 2'h0;
	localparam logic [2:0] DEF_FMT = 3'h0;
	localparam logic DEF_DC = 1'b0;
	localparam logic DEF_BOOST = 1'b0;
	localparam logic DEF_INVERT = 1'b0;
	localparam logic DEF_DOUBLE = 1'b0;
	localparam logic [1:0] DEF_POWER = 2'h3;
	localparam logic [5:0] DEF_VOLUME = 6'h00;
	localparam logic [3:0] DEF_LOW_SHELF = 4'h0;
	localparam logic [1:0] DEF_HIGH_SHELF = 2'h0;
	localparam logic DEF_PEAK_TAP = 1'b1;
	localparam logic [1:0] DEF_EMPH = 2'h0;
	localparam logic DEF_MUTE = 1'b0;
	localparam logic [1:0] DEF_TONE = 2'h0;
	localparam logic [4:0] DEF_MIX_GAIN = 5'h04;
	localparam logic [2:0] DEF_MIC = 3'h0;
	localparam logic [1:0] DEF_MIX_MODE = 2'h0;
	localparam logic DEF_AGC = 1'b0;
	localparam logic [6:0] DEF_IN_GAIN = 7'h00;
	localparam logic [2:0] DEF_AGC_TIME = 3'h0;
	localparam logic [1:0] DEF_AGC_LEVEL = 2'h0;

endpackage

// ===== hdl/link_byte_if.sv
// byte-level carrier between the link shifter and the register decoder
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface link_byte_if;
	logic [7:0] byte_data;
	logic byte_valid;
	logic byte_is_addr;
	logic tx_en;
	logic [7:0] tx_byte;

	modport rx (output byte_data, output byte_valid, output byte_is_addr,
		input tx_en, input tx_byte);
	modport dec (input byte_data, input byte_valid, input byte_is_addr,
		output tx_en, output tx_byte);
endinterface
`default_nettype wire

// ===== hdl/link_shifter.sv
// bit-level side of the three-wire control port: pin sync, edge finding,
// byte assembly and peak read shift-out
// assumes the link clock is much slower than clk_i (8 samples a period)
`timescale 1ns/1ps
`default_nettype none
module link_shifter (
	input wire logic clk_i,       // system clock
	input wire logic rst_i,       // async reset, active high
	input wire logic data_i,      // data pin level
	input wire logic mode_i,      // mode pin, low = address
	input wire logic sclk_i,      // link clock pin
	link_byte_if.rx lnk,          // byte carrier to the decoder
	output logic data_o,          // data pin drive value
	output logic data_oe_n_o      // data pin enable, low drives
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic clk_d;
		logic mode_d;
		logic [2:0] cnt;
		logic [7:0] rx_sr;
		logic [7:0] tx_sr;
		logic [7:0] byte_q;
		logic byte_v;
		logic is_addr;
		logic oe_n;
	} shift_state_t;

	shift_state_t q_ff, nxt_q;
	logic rise, fall;
	logic [7:0] shifted;

	always_comb begin
		nxt_q = q_ff;
		nxt_q.byte_v = 1'b0;
		nxt_q.s1 = {data_i, mode_i, sclk_i};
		nxt_q.s2 = q_ff.s1;
		nxt_q.clk_d = q_ff.s2[0];
		nxt_q.mode_d = q_ff.s2[1];
		rise = q_ff.s2[0] & ~q_ff.clk_d;
		fall = ~q_ff.s2[0] & q_ff.clk_d;
		shifted = {q_ff.s2[2], q_ff.rx_sr[7:1]};
		// a mode change abandons any partial byte
		if (q_ff.s2[1] != q_ff.mode_d) begin
			nxt_q.cnt = 3'h0;
		end else if (rise) begin
			nxt_q.rx_sr = shifted;
			nxt_q.cnt = q_ff.cnt + 3'h1;
			if (q_ff.cnt == 3'h7) begin
				nxt_q.byte_q = shifted;
				nxt_q.byte_v = 1'b1;
				nxt_q.is_addr = ~q_ff.s2[1];
			end
		end
		// reload between bytes; advance on falling edges so the host
		// sees a settled bit on its rising edge
		if (q_ff.cnt == 3'h0 && !rise) begin
			nxt_q.tx_sr = lnk.tx_byte;
		end else if (fall) begin
			nxt_q.tx_sr = {1'b0, q_ff.tx_sr[7:1]};
		end
		nxt_q.oe_n = ~(lnk.tx_en & q_ff.s2[1]);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q_ff <= '0;
			q_ff.oe_n <= 1'b1;
			// link clock idles high: start its samples there so that the
			// release of reset is not taken for a rising edge
			q_ff.s1[0] <= 1'b1;
			q_ff.s2[0] <= 1'b1;
			q_ff.clk_d <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign lnk.byte_data = q_ff.byte_q;
	assign lnk.byte_valid = q_ff.byte_v;
	assign lnk.byte_is_addr = q_ff.is_addr;
	assign data_o = q_ff.tx_sr[0];
	assign data_oe_n_o = q_ff.oe_n;
endmodule
`default_nettype wire

// ===== sim/host_link_model.sv
// host side of the three-wire control port: byte writes and peak reads
// assumes the bench resolves the data wire from both parties' enables
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	input wire logic data_i,  // resolved data wire
	output logic mode_o,      // mode pin, low = address
	output logic sclk_o,      // link clock, idle high
	output logic drv_en_o,    // host drives the data wire
	output logic drv_d_o      // host data value
);
	localparam time HALF = 200ns;
	initial begin
		mode_o = 1'b1;
		sclk_o = 1'b1;
		drv_en_o = 1'b0;
		drv_d_o = 1'b0;
	end
	// clock stands still between bytes; nbits below 8 tears a byte
	task automatic send(input logic md, input logic [7:0] b, input int nbits);
		int i;
		mode_o = md;
		drv_en_o = 1'b1;
		#HALF;
		for (i = 0; i < nbits; i++) begin
			sclk_o = 1'b0;
			drv_d_o = b[i];
			#HALF;
			sclk_o = 1'b1;
			#HALF;
		end
		// the wire stays driven between writes; only a read lets it go
	endtask
	task automatic read(output logic [7:0] b);
		int i;
		drv_en_o = 1'b0;
		mode_o = 1'b1;
		#HALF;
		for (i = 0; i < 8; i++) begin
			sclk_o = 1'b0;
			#HALF;
			b[i] = data_i;
			sclk_o = 1'b1;
			#HALF;
		end
		// mode low hands the wire back to the host
		mode_o = 1'b0;
		#HALF;
	endtask
endmodule
`default_nettype wire

// ===== sim/test_codec_ctrl_decode.sv
// self-checking bench of the control register decoder
// assumes the host model drives the link pins asynchronously to CLK_I
`timescale 1ns/1ps
`default_nettype none
module test_codec_ctrl_decode;
	import codec_ctrl_pkg::*;
	typedef struct packed {logic rd; logic [75:0] v;} note_t;
	logic clk, rst, data_o, oe_n, mode, sclk, drv_en, drv_d, clr, sel;
	logic [5:0] peak, vol, shelf, misc;
	logic [7:0] rd_b;
	logic [6:0] st1;
	logic [4:0] mix1, mix2, mic, agc_lo, ig_hi, tim;
	logic [2:0] fmt, ptr;
	logic [1:0] ratio, cls;
	logic dc;
	wire logic [75:0] snap;
	wire logic data_w;
	note_t q[$];
	note_t nt, got;
	event ev;
	int n_fail, total_checks, n_clr, seed, i;
	// a released wire shows the inverse of its last value, never a hold
	assign data_w = (oe_n === 1'b0) ? data_o : (drv_en ? drv_d : ~drv_d);
	codec_ctrl_decode i_codec_ctrl_decode (.CLK_I(clk), .SYS_RST_I(rst),
		.CTRL_DATA_I(data_w), .CTRL_DATA_O(data_o),
		.CTRL_DATA_OE_N_O(oe_n), .CTRL_MODE_I(mode), .CTRL_CLK_I(sclk),
		.PEAK_LEVEL_I(peak), .PEAK_CLEAR_O(clr),
		.MASTER_CLOCK_RATIO_O(snap[75:74]), .CLOCK_MULT_O(snap[73:64]),
		.SERIAL_FORMAT_O(snap[63:61]), .FMT_I2S_O(snap[60]),
		.FMT_MSB_OUT_O(snap[59]), .FMT_LSB_IN_O(snap[58]),
		.FMT_LSB_WIDTH_O(snap[57:56]), .OFFSET_REMOVAL_ENABLE_O(snap[55]),
		.DAC_OUTPUT_BOOST_O(snap[54]), .ADC_INPUT_BOOST_O(snap[53]),
		.ADC_INVERT_O(snap[52]), .DAC_INVERT_O(snap[51]),
		.DOUBLE_RATE_O(snap[50]), .CONVERTER_POWER_FIELD_O(snap[49:48]),
		.ADC_POWER_ON_O(snap[47]), .DAC_POWER_ON_O(snap[46]),
		.VOLUME_ATTEN_O(snap[45:40]), .LOW_SHELF_GAIN_O(snap[39:36]),
		.HIGH_SHELF_GAIN_O(snap[35:34]), .PEAK_TAP_POINT_O(snap[33]),
		.EMPHASIS_UNDO_SELECT_O(snap[32:31]), .MUTE_ENABLE_O(snap[30]),
		.TONE_MODE_O(snap[29:28]), .MIXER_GAIN_CH1_O(snap[27:23]),
		.MIXER_GAIN_CH2_O(snap[22:18]), .MIC_SENSITIVITY_O(snap[17:15]),
		.MIXER_MODE_O(snap[14:13]), .AUTO_GAIN_ENABLE_O(snap[12]),
		.INPUT_GAIN_O(snap[11:5]), .AUTO_GAIN_TIME_O(snap[4:2]),
		.AUTO_GAIN_LEVEL_O(snap[1:0]));
	host_link_model i_host_link_model (.data_i(data_w), .mode_o(mode),
		.sclk_o(sclk), .drv_en_o(drv_en), .drv_d_o(drv_d));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [75:0] seen, input logic [75:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [75:0] exp_snap();
		logic [9:0] m;
		m = (ratio == RATIO_512) ? MULT_512 : (ratio == RATIO_384) ? MULT_384 :
			(ratio == RATIO_256) ? MULT_256 : MULT_NONE;
		return {ratio, m, fmt, fmt == 3'h0, fmt[2], fmt[1:0] != 2'h0,
			fmt[1:0], dc, st1, st1[1], st1[0], vol, shelf, misc, mix1, mix2,
			mic, agc_lo[4], ig_hi, agc_lo[1:0], tim};
	endfunction
	task automatic defaults(input logic keep);
		if (!keep)
			ratio = 2'h0;
		{fmt, dc, st1, vol, shelf, misc, ptr} = {4'h0, 7'h03, 12'h000, 6'h20, 3'h0};
		{mix1, mix2, mic, agc_lo, ig_hi, tim} = {5'h04, 5'h04, 20'h00000};
	endtask
	task automatic post();
		nt.rd = 1'b0;
		nt.v = exp_snap();
		q.push_back(nt);
		repeat (10) @(posedge clk);
		#1 ->ev;
	endtask
	task automatic adr(input logic [7:0] b);
		i_host_link_model.send(1'b0, b, 8);
		sel = (b[7:2] == DEV_ADDR);
		cls = b[1:0];
	endtask
	task automatic wr(input logic [7:0] b);
		i_host_link_model.send(1'b1, b, 8);
		if (sel && cls == STATUS_TYPE) begin
			if (b[7])
				st1 = b[6:0];
			else if (b[6])
				defaults(1'b1);
			else
				{ratio, fmt, dc} = b[5:0];
		end else if (sel && cls == SOUND_WRITE_TYPE) begin
			case (b[7:6])
				SEL_VOLUME: vol = b[5:0];
				SEL_SHELF: shelf = b[5:0];
				SEL_MISC: misc = b[5:0];
				default: if (!b[5]) ptr = b[2:0]; else case (ptr)
					EXT_MIX1: mix1 = b[4:0];
					EXT_MIX2: mix2 = b[4:0];
					EXT_MIC: mic = b[4:0];
					EXT_AGC_GAIN_LO: agc_lo = b[4:0];
					EXT_GAIN_HI: ig_hi = b[4:0];
					EXT_AGC_TIME: tim = b[4:0];
					default: ;
				endcase
			endcase
		end
		post();
	endtask
	always @(posedge clk)
		if (clr === 1'b1)
			n_clr++;
	initial forever begin
		@(ev);
		got = q.pop_front();
		check(got.rd ? {68'h0, rd_b} : snap, got.v);
	end
	initial begin
		#2ms;
		n_fail++;
		give_verdict();
	end
	initial begin
		{seed, rst, peak, sel, cls, n_fail, total_checks, n_clr} = {32'hacd3, 1'b1, 6'h00, 3'h0, 96'h0};
		defaults(1'b0);
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		post(); // reset values
		adr(8'h16);
		for (i = 0; i < 4; i++)
			wr({1'b1, 5'($random(seed)), i[1:0]});
		for (i = 0; i < 8; i++)
			wr({2'h0, i[1:0], i[2:0], i[0]});
		adr(8'h14);
		for (i = 0; i < 3; i++)
			wr({i[1:0], 6'($random(seed))});
		for (i = 0; i < 8; i++) begin
			wr({5'h18, i[2:0]});
			wr({3'h7, 5'($random(seed))});
			wr({3'h7, 5'($random(seed))});
		end
		// torn byte, foreign address and unused class leave all fields alone
		i_host_link_model.send(1'b1, 8'h3f, 5);
		adr(8'h18);
		wr(8'h3f);
		adr(8'h17);
		wr(8'h3f);
		adr(8'h16);
		wr(8'h28);
		wr(8'h7f);
		adr(8'h14);
		wr(8'hff);
		@(posedge clk);
		#1 peak = 6'($random(seed));
		adr(8'h15);
		nt.rd = 1'b1;
		nt.v = {70'h0, peak};
		q.push_back(nt);
		i_host_link_model.read(rd_b);
		->ev;
		repeat (4) @(posedge clk);
		check(76'(n_clr), 76'h1);
		give_verdict();
	end
endmodule
`default_nettype wire
